//--- rtl/iob_dev.sv
// device end: decodes commands, holds control, flags and interrupt channels
`default_nettype none
// Contract
// - all transfers share the 36 data lines
// - control-out clear pulse then set pulse
// - data may be captured on clear pulse
// - act only on pulses with device selected
// - data-out clear sets busy, clears done
// - status driven exactly while status level
// - data-in level drives data, busy/done
// - control-out carries 18 bits, duplicated halves
// - wider control needs more device numbers
// - processor settles data 1 us before clear
// - drive lines only when selected and reading
// - skip-testable status in right half
// - channel field from data bits 33..35
// - one-of-eight decoder, channel 0 drives nothing
// - interrupt conditions cleared when serviced
// - status flag for every interrupt cause
// - bus reset zeroes every channel field
// - separate channel field per assignment
// - control-out can set and clear done
// - block mode suppresses other interrupts
// - request held while data available
// - seven complementary select pairs, full decode
// - bus reset ungated by select
module iob_dev
   import iob_pkg::*;
#(
   parameter logic [iob_pkg::SEL_W-1:0] DEV_NUM = iob_pkg::DEV_NUM_DEF
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   iob_if.dev                              bus,
   output logic [iob_pkg::DATA_W-1:0]      out_word,
   output logic                            out_valid,
   input  wire logic [iob_pkg::DATA_W-1:0] in_word,
   input  wire logic                       xfer_done,
   input  wire logic                       error_event,
   input  wire logic                       more_data
);
   import iob_pkg::*;

   ///////////////////////////////////////////////////////////////////
   // synchronised bus inputs
   logic [6:0]          lvl;
   logic [6:0]          rise;
   logic [DATA_W-1:0]   data_s1_r;
   logic [DATA_W-1:0]   data_s2_r;
   logic [2*SEL_W-1:0]  sel_s1_r;
   logic [2*SEL_W-1:0]  sel_s2_r;

   iob_edge #(.N(7)) u_edge (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_async ({bus.bus_reset_pulse, bus.data_read_level, bus.status_read_level,
                  bus.dat_out_set_pulse, bus.dat_out_clear_pulse,
                  bus.ctl_out_set_pulse, bus.ctl_out_clear_pulse}),
      .level    (lvl),
      .rise     (rise)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_s1_r <= '0;
         data_s2_r <= '0;
         sel_s1_r  <= '0;
         sel_s2_r  <= '0;
      end
      else
      begin
         data_s1_r <= bus.data_lines;
         data_s2_r <= data_s1_r;
         sel_s1_r  <= bus.device_select_pairs;
         sel_s2_r  <= sel_s1_r;
      end
   end

   ///////////////////////////////////////////////////////////////////
   // select decode: pair i is {true, complement} of number bit i
   wire logic [SEL_W-1:0] sel_true = sel_s2_r[2*SEL_W-1:SEL_W];
   wire logic [SEL_W-1:0] sel_comp = sel_s2_r[SEL_W-1:0];
   wire logic selected = (sel_true == DEV_NUM) && (sel_comp == ~DEV_NUM);

   // command strobes qualified by select; bus reset is not
   wire logic co_clr  = rise[0] & selected;
   wire logic co_set  = rise[1] & selected;
   wire logic do_clr  = rise[2] & selected;
   wire logic do_set  = rise[3] & selected;
   wire logic st_lvl  = lvl[4] & selected;
   wire logic di_lvl  = lvl[5] & selected;
   wire logic di_rise = rise[5] & selected;
   wire logic brst    = rise[6];

   // control word is the right-half copy of the 18 bits
   wire logic [HALF_W-1:0] ctl_in = data_s2_r[HALF_W-1:0];

   ///////////////////////////////////////////////////////////////////
   // control and flag registers
   logic [CHAN_W-1:0]  chan_done_r;
   logic [CHAN_W-1:0]  chan_err_r;
   logic               block_r;
   logic               done_r;
   logic               busy_r;
   logic               err_r;
   logic [DATA_W-1:0]  out_r;
   logic               out_v_r;

   // data-out clear captures the word and starts output
   wire logic done_set = xfer_done | (co_set & ctl_in[F_SET_DONE]);
   wire logic done_clr = (do_clr | di_rise | (co_set & ctl_in[F_CLR_DONE]))
                         & ~more_data;
   wire logic err_set  = error_event | (co_set & ctl_in[F_SET_ERR]);
   wire logic err_clr  = co_set & ctl_in[F_CLR_ERR];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chan_done_r <= CHAN_RST;
         chan_err_r  <= CHAN_RST;
         block_r     <= 1'b0;
         done_r      <= 1'b0;
         busy_r      <= 1'b0;
         err_r       <= 1'b0;
         out_r       <= '0;
         out_v_r     <= 1'b0;
      end
      // bus reset acts without select
      else if (brst)
      begin
         chan_done_r <= CHAN_RST;
         chan_err_r  <= CHAN_RST;
         block_r     <= 1'b0;
         done_r      <= 1'b0;
         busy_r      <= 1'b0;
         err_r       <= 1'b0;
         out_v_r     <= 1'b0;
      end
      else
      begin
         // clear pulse empties control, set pulse reloads it
         if (co_clr)
         begin
            chan_done_r <= CHAN_RST;
            chan_err_r  <= CHAN_RST;
            block_r     <= 1'b0;
         end
         else if (co_set)
         begin
            chan_done_r <= ctl_in[F_CHAN_DONE +: CHAN_W];
            chan_err_r  <= ctl_in[F_CHAN_ERR +: CHAN_W];
            block_r     <= ctl_in[F_BLOCK];
         end
         // set wins over clear
         if (done_set)
            done_r <= 1'b1;
         else if (done_clr)
            done_r <= 1'b0;
         // busy from the service command until transfer completes
         if (do_clr | di_rise)
            busy_r <= 1'b1;
         else if (xfer_done)
            busy_r <= 1'b0;
         if (err_set)
            err_r <= 1'b1;
         else if (err_clr)
            err_r <= 1'b0;
         // capture on the clear pulse, one-cycle strobe
         out_v_r <= do_clr;
         if (do_clr)
            out_r <= data_s2_r;
      end
   end

   ///////////////////////////////////////////////////////////////////
   // status word and bus drive
   logic [HALF_W-1:0] status_r;
   always_comb
   begin
      status_r = '0;
      status_r[S_DONE]  = done_r;
      status_r[S_BUSY]  = busy_r;
      status_r[S_ERR]   = err_r;
      status_r[S_BLOCK] = block_r;
      status_r[S_CHAN_DONE +: CHAN_W] = chan_done_r;
      status_r[S_CHAN_ERR +: CHAN_W]  = chan_err_r;
   end

   // read word selection; lines stay low when not driving
   wire logic              drive_en    = st_lvl | di_lvl;
   wire logic [DATA_W-1:0] status_word = {{HALF_W{1'b0}}, status_r};
   wire logic [DATA_W-1:0] read_word   = st_lvl ? status_word : in_word;

   assign bus.dev_data_oe = drive_en;
   assign bus.dev_data    = drive_en ? read_word : '0;

   // block mode keeps error off the bus during data transfer
   wire logic err_req = err_r & ~block_r;
   wire logic [NREQ-1:0] req_done = iob_chan_dec(chan_done_r, done_r);
   wire logic [NREQ-1:0] req_err  = iob_chan_dec(chan_err_r, err_req);
   assign bus.irq_channel_lines = req_done | req_err;

   assign out_word  = out_r;
   assign out_valid = out_v_r;
endmodule : iob_dev
`default_nettype wire

//--- inc/iob_pkg.sv
// package: constants and types for the 36-bit io bus device interface
`default_nettype none
package iob_pkg;
   localparam int unsigned DATA_W        = 36;
   localparam int unsigned HALF_W        = 18;
   localparam int unsigned SEL_W         = 7;
   localparam int unsigned CHAN_W        = 3;
   localparam int unsigned NREQ          = 7;
   // clock and bus timing
   localparam int unsigned CLK_PS        = 4000;
   localparam int unsigned READ_LEVEL_NS = 2500;
   localparam int unsigned SETTLE_NS     = 1000;
   localparam int unsigned SELECT_NS     = 200;
   localparam int unsigned PULSE_NS      = 400;
   localparam int unsigned READ_CYC      = (READ_LEVEL_NS * 1000) / CLK_PS;
   localparam int unsigned SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int unsigned SELECT_CYC    = (SELECT_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int unsigned PULSE_CYC     = (PULSE_NS * 1000) / CLK_PS;
   localparam int unsigned CNT_W         = 10;
   // device control word fields (right half copy, bit 35 = lsb of word)
   localparam int unsigned F_CHAN_DONE   = 0;   // data bits 33..35 -> vector 2..0
   localparam int unsigned F_CHAN_ERR    = 3;   // data bits 30..32
   localparam int unsigned F_SET_DONE    = 6;
   localparam int unsigned F_CLR_DONE    = 7;
   localparam int unsigned F_CLR_ERR     = 8;
   localparam int unsigned F_SET_ERR     = 9;
   localparam int unsigned F_BLOCK       = 10;
   // status word fields
   localparam int unsigned S_DONE        = 0;
   localparam int unsigned S_BUSY        = 1;
   localparam int unsigned S_ERR         = 2;
   localparam int unsigned S_BLOCK       = 3;
   localparam int unsigned S_CHAN_DONE   = 4;
   localparam int unsigned S_CHAN_ERR    = 7;
   localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
   localparam logic [SEL_W-1:0] DEV_NUM_DEF = 7'h2_0;
   // host apb register map
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_WDATA  = 8'h04;
   localparam logic [7:0] A_RDATA  = 8'h08;
   localparam logic [7:0] A_STATUS = 8'h0c;
   localparam logic [7:0] A_IRQ    = 8'h10;
   localparam logic [2:0] OP_CONTROL_OUT_CMD  = 3'h1;
   localparam logic [2:0] OP_STATUS_IN_CMD  = 3'h2;
   localparam logic [2:0] OP_DATAO = 3'h3;
   localparam logic [2:0] OP_DATA_IN_CMD = 3'h4;
   localparam logic [2:0] OP_RESET = 3'h5;
   typedef enum logic [2:0] {H_IDLE, H_SETTLE, H_CLR, H_GAP, H_SET, H_READ, H_RST} iob_hstate_t;

   // one-hot decode of channel number, channel 0 drives nothing
   function automatic logic [NREQ-1:0] iob_chan_dec(input logic [CHAN_W-1:0] ch,
                                                    input logic en);
      logic [NREQ-1:0] v;
      v = '0;
      if (en && ch != CHAN_RST)
         v[ch - 3'h1] = 1'b1;
      return v;
   endfunction : iob_chan_dec
endpackage : iob_pkg
`default_nettype wire

//--- inc/iob_if.sv
// interface: shared io bus between processor end and device end
`default_nettype none
interface iob_if;
   import iob_pkg::*;
   logic [iob_pkg::DATA_W-1:0] host_data;
   logic                       host_data_oe;
   logic [iob_pkg::DATA_W-1:0] dev_data;
   logic                       dev_data_oe;
   logic [2*iob_pkg::SEL_W-1:0] device_select_pairs;
   logic                       ctl_out_clear_pulse;
   logic                       ctl_out_set_pulse;
   logic                       dat_out_clear_pulse;
   logic                       dat_out_set_pulse;
   logic                       status_read_level;
   logic                       data_read_level;
   logic                       bus_reset_pulse;
   logic [iob_pkg::NREQ-1:0]   irq_channel_lines;
   wire  [iob_pkg::DATA_W-1:0] data_lines;
   // wired bus: whichever end enables drives, else zero
   assign data_lines = host_data_oe ? host_data : (dev_data_oe ? dev_data : '0);
   modport host (output host_data, host_data_oe, device_select_pairs, ctl_out_clear_pulse,
                 ctl_out_set_pulse, dat_out_clear_pulse, dat_out_set_pulse,
                 status_read_level, data_read_level, bus_reset_pulse,
                 input data_lines, irq_channel_lines);
   modport dev  (output dev_data, dev_data_oe, irq_channel_lines,
                 input data_lines, device_select_pairs, ctl_out_clear_pulse,
                 ctl_out_set_pulse, dat_out_clear_pulse, dat_out_set_pulse,
                 status_read_level, data_read_level, bus_reset_pulse);
endinterface : iob_if
`default_nettype wire

//--- rtl/iob_edge.sv
// synchroniser with single-cycle rising-edge strobe
`default_nettype none
module iob_edge #(
   parameter int unsigned N = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] in_async,
   output logic      [N-1:0] level,
   output logic      [N-1:0] rise
);
   logic [N-1:0] s1_r;
   logic [N-1:0] s2_r;
   logic [N-1:0] s3_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= in_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign level = s2_r;
   assign rise  = s2_r & ~s3_r;
endmodule : iob_edge
`default_nettype wire

//--- rtl/iob_host.sv
// processor end: apb-commanded sequencer of io bus commands
`default_nettype none
module iob_host
   import iob_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   iob_if.host              bus
);
   import iob_pkg::*;

   iob_hstate_t        st_r;
   logic [CNT_W-1:0]   cnt_r;
   logic [2:0]         op_r;
   logic [SEL_W-1:0]   dev_r;
   logic [DATA_W-1:0]  wd_r;
   logic [DATA_W-1:0]  rd_r;
   logic [31:0]        prdata_r;

   wire logic acc   = psel & penable;
   wire logic wr    = acc & pwrite;
   wire logic idle  = (st_r == H_IDLE);
   wire logic start = wr & (paddr == A_CMD) & idle;
   wire logic known = (paddr == A_CMD) | (paddr == A_WDATA) | (paddr == A_RDATA)
                    | (paddr == A_STATUS) | (paddr == A_IRQ);
   wire logic is_out = (op_r == OP_CONTROL_OUT_CMD) | (op_r == OP_DATAO);
   wire logic cnt_end = (cnt_r == '0);

   assign pready  = 1'b1;
   assign pslverr = acc & ~known;
   assign prdata  = prdata_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r  <= H_IDLE;
         cnt_r <= '0;
         op_r  <= 3'h0;
         dev_r <= '0;
         wd_r  <= '0;
         rd_r  <= '0;
      end
      else
      begin
         if (wr & (paddr == A_WDATA) & idle)
            wd_r <= {pwdata[HALF_W-1:0], pwdata[HALF_W-1:0]};
         if (!cnt_end)
            cnt_r <= cnt_r - 1'b1;
         unique case (st_r)
            H_IDLE:
               if (start)
               begin
                  op_r  <= pwdata[2:0];
                  dev_r <= pwdata[8+:SEL_W];
                  st_r  <= (pwdata[2:0] == OP_RESET) ? H_RST : H_SETTLE;
                  // counter runs down to zero inclusive; reset pulse loads one less, settle loads the full SETTLE_CYC
                  cnt_r <= (pwdata[2:0] == OP_RESET) ? CNT_W'(PULSE_CYC - 1)
                                                     : CNT_W'(SETTLE_CYC);
               end
            H_SETTLE:
               if (cnt_end)
               begin
                  st_r  <= is_out ? H_CLR : H_READ;
                  cnt_r <= is_out ? CNT_W'(PULSE_CYC - 1) : CNT_W'(READ_CYC - 1);
               end
            H_CLR:
               if (cnt_end)
               begin
                  st_r  <= H_GAP;
                  cnt_r <= CNT_W'(PULSE_CYC);
               end
            H_GAP:
               if (cnt_end)
               begin
                  st_r  <= H_SET;
                  cnt_r <= CNT_W'(PULSE_CYC - 1);
               end
            H_SET:
               if (cnt_end)
                  st_r <= H_IDLE;
            H_READ:
               if (cnt_end)
                  st_r <= H_IDLE;
               else if (cnt_r == CNT_W'(1))
                  rd_r <= bus.data_lines;
            H_RST:
               if (cnt_end)
                  st_r <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= '0;
      else if (psel & ~penable & ~pwrite)
         prdata_r <= (paddr == A_RDATA) ? rd_r[31:0]
                   : (paddr == A_STATUS) ? {rd_r[35:32], 24'h00_0000, 3'h0, ~idle}
                   : (paddr == A_IRQ) ? {25'h000_0000, bus.irq_channel_lines}
                   : (paddr == A_WDATA) ? wd_r[31:0] : 32'h0000_0000;
   end

   wire logic active = ~idle & (st_r != H_RST);
   assign bus.device_select_pairs = active ? {dev_r, ~dev_r} : '0;
   assign bus.host_data    = wd_r;
   assign bus.host_data_oe = active & is_out;
   assign bus.ctl_out_clear_pulse = (st_r == H_CLR) & (op_r == OP_CONTROL_OUT_CMD);
   assign bus.ctl_out_set_pulse   = (st_r == H_SET) & (op_r == OP_CONTROL_OUT_CMD);
   assign bus.dat_out_clear_pulse = (st_r == H_CLR) & (op_r == OP_DATAO);
   assign bus.dat_out_set_pulse   = (st_r == H_SET) & (op_r == OP_DATAO);
   assign bus.status_read_level   = (st_r == H_READ) & (op_r == OP_STATUS_IN_CMD);
   assign bus.data_read_level     = (st_r == H_READ) & (op_r == OP_DATA_IN_CMD);
   assign bus.bus_reset_pulse     = (st_r == H_RST);
endmodule : iob_host
`default_nettype wire

//--- dv/iob_checker.sv
// checker: timing and ownership properties of the shared io bus
`default_nettype none
module iob_checker
   import iob_pkg::*;
#(
   parameter logic [iob_pkg::SEL_W-1:0] DEV_NUM = iob_pkg::DEV_NUM_DEF
) (
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic [iob_pkg::DATA_W-1:0]    host_data,
   input wire logic                          host_data_oe,
   input wire logic [iob_pkg::DATA_W-1:0]    dev_data,
   input wire logic                          dev_data_oe,
   input wire logic [2*iob_pkg::SEL_W-1:0]   device_select_pairs,
   input wire logic                          ctl_out_clear_pulse,
   input wire logic                          ctl_out_set_pulse,
   input wire logic                          dat_out_clear_pulse,
   input wire logic                          status_read_level,
   input wire logic                          data_read_level,
   input wire logic                          bus_reset_pulse,
   input wire logic [iob_pkg::NREQ-1:0]      irq_channel_lines
);
   import iob_pkg::*;
   localparam logic [9:0] SETTLE_MIN = 10'h0f0;
   wire logic             sel_ok;
   wire logic             rd_any;
   logic [DATA_W-1:0]     last_r;
   logic [9:0]            stab_r;
   logic [9:0]            rd_len_r;
   logic                  clr_seen_r;
   assign sel_ok = device_select_pairs == {DEV_NUM, ~DEV_NUM};
   assign rd_any = status_read_level | data_read_level;
   // stable-data run length, status level length, clear-before-set memory
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_r     <= '0;
         stab_r     <= '0;
         rd_len_r   <= '0;
         clr_seen_r <= 1'b0;
      end
      else
      begin
         last_r     <= host_data;
         stab_r     <= (!host_data_oe || host_data != last_r) ? '0 : stab_r + {9'h000, ~&stab_r};
         rd_len_r   <= status_read_level ? rd_len_r + 10'h001 : '0;
         clr_seen_r <= ctl_out_clear_pulse | (clr_seen_r & ~ctl_out_set_pulse);
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_oe_cause;
      dev_data_oe |-> $past(rd_any && sel_ok, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("device drove lines unaddressed");
   property p_oe_rise;
      $rose(rd_any) && sel_ok |-> ##[1:3] dev_data_oe;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("device did not answer read");
   property p_no_fight;
      !(host_data_oe && dev_data_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive data lines");
   property p_halves;
      host_data_oe |-> host_data[DATA_W-1:HALF_W] == host_data[HALF_W-1:0];
   endproperty
   a_halves: assert property (p_halves) else $error("outgoing halves differ");
   property p_clr_first;
      $rose(ctl_out_set_pulse) |-> clr_seen_r;
   endproperty
   a_clr_first: assert property (p_clr_first) else $error("set pulse without clear");
   property p_settle;
      $rose(ctl_out_clear_pulse || dat_out_clear_pulse) |-> stab_r >= SETTLE_MIN;
   endproperty
   a_settle: assert property (p_settle) else $error("data not settled before clear");
   property p_read_len;
      $fell(status_read_level) |-> rd_len_r == 10'(READ_CYC);
   endproperty
   a_read_len: assert property (p_read_len) else $error("status level length wrong");
   property p_reset_irq;
      $rose(bus_reset_pulse) |-> ##4 (irq_channel_lines == '0) [*8];
   endproperty
   a_reset_irq: assert property (p_reset_irq) else $error("request after bus reset");
   property p_status_left;
      dev_data_oe && $past(status_read_level, 2) |-> dev_data[DATA_W-1:HALF_W] == '0;
   endproperty
   a_status_left: assert property (p_status_left) else $error("status left half set");
   c_read: cover property ($rose(dev_data_oe));
   c_set: cover property ($rose(ctl_out_set_pulse));
   c_reset: cover property ($rose(bus_reset_pulse));
   c_irq: cover property (irq_channel_lines != '0);
endmodule : iob_checker
`default_nettype wire

//--- dv/io_bus_device_interface_test.sv
// testbench: apb-driven processor end against device end
`default_nettype none
module io_bus_device_interface_test;
   import iob_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [SEL_W-1:0] DEV = DEV_NUM_DEF;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, q;
   logic [DATA_W-1:0] in_word, out_word, ov_word, wexp;
   logic              xfer_done, error_event, more_data, out_valid;
   int                error_cnt, checked, ov_cnt;
   iob_if iob_if_i ();
   iob_host iob_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(iob_if_i));
   iob_dev #(.DEV_NUM(DEV)) iob_dev_i (.pclk(pclk), .presetn(presetn), .bus(iob_if_i),
      .out_word(out_word), .out_valid(out_valid), .in_word(in_word), .xfer_done(xfer_done),
      .error_event(error_event), .more_data(more_data));
   iob_checker #(.DEV_NUM(DEV)) iob_checker_i (.pclk(pclk), .presetn(presetn),
      .host_data(iob_if_i.host_data), .host_data_oe(iob_if_i.host_data_oe),
      .dev_data(iob_if_i.dev_data), .dev_data_oe(iob_if_i.dev_data_oe),
      .device_select_pairs(iob_if_i.device_select_pairs),
      .ctl_out_clear_pulse(iob_if_i.ctl_out_clear_pulse),
      .ctl_out_set_pulse(iob_if_i.ctl_out_set_pulse),
      .dat_out_clear_pulse(iob_if_i.dat_out_clear_pulse),
      .status_read_level(iob_if_i.status_read_level),
      .data_read_level(iob_if_i.data_read_level),
      .bus_reset_pulse(iob_if_i.bus_reset_pulse),
      .irq_channel_lines(iob_if_i.irq_channel_lines));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(n), 32'h0000_0001);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   // one bus command; waits until the sequencer is idle again
   task automatic op(input logic [2:0] o, input logic [SEL_W-1:0] dv, input logic [17:0] wd);
      apb(1'b1, A_WDATA, {14'h0, wd});
      apb(1'b1, A_CMD, {17'h0, dv, 5'h0, o});
      do
         apb(1'b0, A_STATUS, 32'h0);
      while (q[0] !== 1'b0);
   endtask : op
   task automatic dev_pulse(input logic err);
      @(posedge pclk);
      xfer_done <= ~err;
      error_event <= err;
      @(posedge pclk);
      xfer_done <= 1'b0;
      error_event <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : dev_pulse
   always @(posedge pclk)
      if (out_valid === 1'b1)
      begin
         ov_cnt <= ov_cnt + 1;
         ov_word <= out_word;
      end
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial
   begin
      #200_000;
      error_cnt++;
      $display("Error at %0t ns: watchdog expired", $time);
      end_sim();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, xfer_done, error_event, more_data} = '0;
      {paddr, pwdata, in_word} = '0;
      {error_cnt, checked, ov_cnt} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_IRQ, 32'h0000_0000);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      for (int ch = 0; ch < 8; ch++)
      begin
         op(OP_CONTROL_OUT_CMD, DEV, 18'(ch) | 18'h0_0040);
         rd(A_IRQ, (ch == 0) ? 32'h0 : (32'h1 << (ch - 1)));
      end
      op(OP_CONTROL_OUT_CMD, DEV, 18'h0_0045);
      op(OP_STATUS_IN_CMD, DEV, 18'h0);
      rd(A_RDATA, 32'h0000_0051);
      wexp = {18'h2_1234, 18'h2_1234};
      op(OP_DATAO, DEV, 18'h2_1234);
      chk(32'(ov_cnt), 32'h0000_0001);
      chk(ov_word[31:0], wexp[31:0]);
      chk({28'h0, ov_word[35:32]}, {28'h0, wexp[35:32]});
      rd(A_IRQ, 32'h0000_0000);
      op(OP_STATUS_IN_CMD, DEV, 18'h0);
      rd(A_RDATA, 32'h0000_0052);
      dev_pulse(1'b0);
      rd(A_IRQ, 32'h0000_0010);
      in_word <= 36'h9_8765_4321;
      op(OP_DATA_IN_CMD, DEV, 18'h0);
      rd(A_RDATA, 32'h8765_4321);
      rd(A_STATUS, 32'h9000_0000);
      rd(A_IRQ, 32'h0000_0000);
      more_data <= 1'b1;
      dev_pulse(1'b0);
      op(OP_DATAO, DEV, 18'h0_0001);
      rd(A_IRQ, 32'h0000_0010);
      more_data <= 1'b0;
      dev_pulse(1'b0);
      op(OP_CONTROL_OUT_CMD, DEV, 18'h0_009d);
      rd(A_IRQ, 32'h0000_0000);
      dev_pulse(1'b1);
      rd(A_IRQ, 32'h0000_0004);
      op(OP_CONTROL_OUT_CMD, DEV, 18'h0_041d);
      rd(A_IRQ, 32'h0000_0000);
      op(OP_STATUS_IN_CMD, DEV, 18'h0);
      rd(A_RDATA, 32'h0000_01dc);
      op(OP_CONTROL_OUT_CMD, DEV, 18'h0_011d);
      rd(A_IRQ, 32'h0000_0000);
      op(OP_CONTROL_OUT_CMD, DEV + 7'h01, 18'h0_0045);
      rd(A_IRQ, 32'h0000_0000);
      op(OP_STATUS_IN_CMD, DEV + 7'h01, 18'h0);
      rd(A_RDATA, 32'h0000_0000);
      op(OP_CONTROL_OUT_CMD, DEV, 18'h0_0047);
      rd(A_IRQ, 32'h0000_0040);
      op(OP_RESET, DEV, 18'h0);
      rd(A_IRQ, 32'h0000_0000);
      op(OP_STATUS_IN_CMD, DEV, 18'h0);
      rd(A_RDATA, 32'h0000_0000);
      op(OP_CONTROL_OUT_CMD, DEV, 18'h0_0040);
      rd(A_IRQ, 32'h0000_0000);
      end_sim();
   end
endmodule : io_bus_device_interface_test
`default_nettype wire
